// File: core/ppdh_hold_cell.sv
// Hold latch for one user pin: output value, output enable and input level
`timescale 1ns/1ps
`default_nettype none
`include "ppdh_defs.svh"

module ppdh_hold_cell
	import ppdh_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Control
	input wire logic track_i,
	// Live values
	input wire logic core_out_i,
	input wire logic core_oe_i,
	input wire logic pad_in_i,
	// Held values
	output logic pad_out_o,
	output logic pad_oe_o,
	output logic core_in_o
);

	logic out_q;
	logic out_d;
	logic oe_q;
	logic oe_d;
	logic in_q;
	logic in_d;

	// ************************************************
	// Next values
	// ************************************************
	always_comb
	begin
		out_d = out_q;
		oe_d = oe_q;
		in_d = in_q;
		if (track_i)
		begin
			out_d = core_out_i;
			oe_d = core_oe_i;
			in_d = pad_in_i;
		end
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			out_q <= 1'b0;
			oe_q <= 1'b0;
			in_q <= 1'b0;
		end
		else
		begin
			out_q <= out_d;
			oe_q <= oe_d;
			in_q <= in_d;
		end
	end

	assign pad_out_o = out_q;
	assign pad_oe_o = oe_q;
	assign core_in_o = in_q;

endmodule

`default_nettype wire

// File: core/ppdh_top.sv
// Pin-controlled power-down sequencer with pin hold latches
`timescale 1ns/1ps
`default_nettype none
`include "ppdh_defs.svh"

module ppdh_top
	import ppdh_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Configuration, taken while reset is low
	input wire logic sleep_enable_i,
	// Sleep pins
	input wire logic sleep_pin_a_i,
	input wire logic sleep_pin_b_i,
	// User pins
	input wire logic [`PPDH_PINS-1:0] pad_in_i,
	output logic [`PPDH_PINS-1:0] pad_out_o,
	output logic [`PPDH_PINS-1:0] pad_oe_o,
	// Core logic side
	input wire logic [`PPDH_PINS-1:0] core_out_i,
	input wire logic [`PPDH_PINS-1:0] core_oe_i,
	output logic [`PPDH_PINS-1:0] core_in_o,
	output logic core_run_o,
	// Sleep pins seen as logic inputs
	output logic core_sleep_a_o,
	output logic core_sleep_b_o,
	// Buried feedback of the sleep pin macrocells
	input wire logic [1:0] core_buried_i,
	output logic [1:0] buried_fb_o,
	// Status
	output logic asleep_o
);

	// ************************************************
	// Declarations
	// ************************************************
	ppdh_state_type state_q;
	ppdh_state_type state_d;
	logic cfg_q;
	logic cfg_d;
	logic [`PPDH_CNT_W-1:0] cnt_q;
	logic [`PPDH_CNT_W-1:0] cnt_d;
	logic track_d;
	logic run_q;
	logic run_d;
	logic asleep_q;
	logic asleep_d;
	logic sleep_a_q;
	logic sleep_a_d;
	logic sleep_b_q;
	logic sleep_b_d;
	logic [1:0] buried_q;
	logic [1:0] buried_d;
	logic sleep_req;

	localparam logic [`PPDH_CNT_W-1:0] WAKE_LAST = `PPDH_CNT_W'(`PPDH_WAKE_CYC - 2);

	function automatic logic is_running(input ppdh_state_type st);
		is_running = (st == PPDH_RUN);
	endfunction

	// ************************************************
	// Sleep request
	// ************************************************
	assign sleep_req = cfg_q & (sleep_pin_a_i | sleep_pin_b_i);

	// ************************************************
	// Power state machine
	// ************************************************
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		cfg_d = cfg_q;
		if (!nrst_i)
		begin
			cfg_d = sleep_enable_i;
		end
		case (state_q)
			PPDH_RUN:
			begin
				cnt_d = '0;
				if (sleep_req)
				begin
					state_d = PPDH_HOLD;
				end
			end
			PPDH_HOLD:
			begin
				cnt_d = '0;
				if (!sleep_req)
				begin
					state_d = PPDH_WAKE;
				end
			end
			PPDH_WAKE:
			begin
				if (sleep_req)
				begin
					state_d = PPDH_HOLD;
					cnt_d = '0;
				end
				else if (cnt_q >= WAKE_LAST)
				begin
					state_d = PPDH_RUN;
					cnt_d = '0;
				end
				else
				begin
					cnt_d = cnt_q + `PPDH_CNT_W'(1);
				end
			end
			default:
			begin
				state_d = PPDH_RUN;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			state_q <= PPDH_RUN;
			cnt_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
		cfg_q <= cfg_d;
	end

	// ************************************************
	// Freeze controls and status
	// ************************************************
	always_comb
	begin
		track_d = is_running(state_d);
		run_d = is_running(state_d);
		asleep_d = !is_running(state_d);
		sleep_a_d = sleep_a_q;
		sleep_b_d = sleep_b_q;
		buried_d = buried_q;
		if (is_running(state_d))
		begin
			sleep_a_d = cfg_q ? 1'b0 : sleep_pin_a_i;
			sleep_b_d = cfg_q ? 1'b0 : sleep_pin_b_i;
			buried_d = core_buried_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			run_q <= 1'b1;
			asleep_q <= 1'b0;
			sleep_a_q <= 1'b0;
			sleep_b_q <= 1'b0;
			buried_q <= 2'h0;
		end
		else
		begin
			run_q <= run_d;
			asleep_q <= asleep_d;
			sleep_a_q <= sleep_a_d;
			sleep_b_q <= sleep_b_d;
			buried_q <= buried_d;
		end
	end

	assign core_run_o = run_q;
	assign asleep_o = asleep_q;
	assign core_sleep_a_o = sleep_a_q;
	assign core_sleep_b_o = sleep_b_q;
	assign buried_fb_o = buried_q;

	// ************************************************
	// Pin hold cells
	// ************************************************
	genvar gi;
	generate
		for (gi = 0; gi < `PPDH_PINS; gi = gi + 1)
		begin : g_pin
			ppdh_hold_cell u_cell
			(
				.clk_i(clk_i),
				.nrst_i(nrst_i),
				.track_i(track_d),
				.core_out_i(core_out_i[gi]),
				.core_oe_i(core_oe_i[gi]),
				.pad_in_i(pad_in_i[gi]),
				.pad_out_o(pad_out_o[gi]),
				.pad_oe_o(pad_oe_o[gi]),
				.core_in_o(core_in_o[gi])
			);
		end
	endgenerate

endmodule

`default_nettype wire

// File: inc/ppdh_defs.svh
// Constants of the pin power-down hold block
`ifndef PPDH_DEFS_SVH
`define PPDH_DEFS_SVH

// Number of general user pins handled by the hold cells
`define PPDH_PINS 8
// Clock period in ns (10 MHz)
`define PPDH_CLK_NS 100
// Longest time to capture state after a sleep pin rises, in ns
`define PPDH_CAPTURE_NS 12
// Longest time from sleep pin low to valid pins again, in ns
`define PPDH_WAKE_NS 1000
// Capture time in cycles, rounded down, never below one
`define PPDH_CAPTURE_CYC ((`PPDH_CAPTURE_NS / `PPDH_CLK_NS) < 1 ? 1 : \
	(`PPDH_CAPTURE_NS / `PPDH_CLK_NS))
// Wake time in cycles, rounded down, never below one
`define PPDH_WAKE_CYC ((`PPDH_WAKE_NS / `PPDH_CLK_NS) < 1 ? 1 : \
	(`PPDH_WAKE_NS / `PPDH_CLK_NS))
// Width of the wake counter
`define PPDH_CNT_W 4
// Reset value of held pin data
`define PPDH_PIN_RST 8'h00

`endif

// File: inc/ppdh_pkg.sv
// Types of the pin power-down hold block
package ppdh_pkg;

	// Power state, Gray coded along run, hold, wake
	typedef enum logic [1:0]
	{
		PPDH_RUN = 2'h0,
		PPDH_HOLD = 2'h1,
		PPDH_WAKE = 2'h3
	} ppdh_state_type;

endpackage

// File: verification/ppdh_checker.sv
// Assertion checker for the pin power-down hold block
`timescale 1ns/1ps
`default_nettype none
`include "ppdh_defs.svh"

module ppdh_checker
(
	// Clock, reset, option, sleep pins
	input wire logic clk_i, nrst_i, sleep_enable_i, sleep_pin_a_i, sleep_pin_b_i,
	// Pins and core
	input wire logic [`PPDH_PINS-1:0] pad_in_i, pad_out_o, pad_oe_o,
	input wire logic [`PPDH_PINS-1:0] core_out_i, core_oe_i, core_in_o,
	input wire logic [1:0] core_buried_i, buried_fb_o,
	// Status
	input wire logic core_run_o, core_sleep_a_o, core_sleep_b_o, asleep_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic req;
	assign req = sleep_enable_i && (sleep_pin_a_i || sleep_pin_b_i);
	sequence s_idle;
		(asleep_o && !req)[*5];
	endsequence
	sequence s_live;
		core_run_o && $past(core_run_o) && $past(nrst_i);
	endsequence
	a_enter_hold: assert property (req |=> asleep_o && !core_run_o)
		else $error("no sleep");
	a_hold_out: assert property (asleep_o |-> $stable(pad_out_o) && $stable(pad_oe_o))
		else $error("out moved");
	a_hold_in: assert property (asleep_o |-> $stable(core_in_o) && $stable(buried_fb_o))
		else $error("in moved");
	a_run_track: assert property (s_live |-> pad_out_o == $past(core_out_i)
		&& pad_oe_o == $past(core_oe_i))
		else $error("out lag");
	a_in_track: assert property (s_live |-> core_in_o == $past(pad_in_i)
		&& buried_fb_o == $past(core_buried_i))
		else $error("in lag");
	a_wake_time: assert property (s_idle ##1 s_idle |=> core_run_o && !asleep_o)
		else $error("late wake");
	a_opt_off: assert property (!sleep_enable_i && $past(nrst_i) |-> !asleep_o
		&& core_sleep_a_o == $past(sleep_pin_a_i)
		&& core_sleep_b_o == $past(sleep_pin_b_i))
		else $error("option off");
	a_pin_masked: assert property (sleep_enable_i |-> !core_sleep_a_o && !core_sleep_b_o)
		else $error("pin seen");
endmodule

bind ppdh_top ppdh_checker i_chk (.*);
`default_nettype wire

// File: verification/ppdh_sys_model.sv
// System logic model driving the sleep pins and user pins
`timescale 1ns/1ps
`default_nettype none
`include "ppdh_defs.svh"

module ppdh_sys_model
(
	// Clock
	input wire logic clk_i,
	// Sleep requests
	input wire logic sleep_a_cmd_i, sleep_b_cmd_i,
	// Pins
	output logic sleep_pin_a_o = 1'b0, sleep_pin_b_o = 1'b0,
	output logic [`PPDH_PINS-1:0] pad_o = 8'h5a
);
	always @(posedge clk_i)
	begin
		// Pins stand still across the edge at which a sleep pin rises
		if (!(sleep_a_cmd_i && !sleep_pin_a_o || sleep_b_cmd_i && !sleep_pin_b_o))
			pad_o <= pad_o + 8'h25;
		sleep_pin_a_o <= sleep_a_cmd_i;
		sleep_pin_b_o <= sleep_b_cmd_i;
	end
endmodule
`default_nettype wire

// File: verification/test_pin_power_down_hold.sv
// Testbench of the pin power-down hold block
`timescale 1ns/1ps
`default_nettype none
`include "ppdh_defs.svh"

module test_pin_power_down_hold;
	logic clk_i = 1'b0, nrst_i = 1'b0, sleep_enable_i = 1'b1, cmd_a = 1'b0, cmd_b = 1'b0;
	logic sleep_pin_a_i, sleep_pin_b_i, core_run_o, core_sleep_a_o, core_sleep_b_o, asleep_o;
	logic [`PPDH_PINS-1:0] pad_in_i, pad_out_o, pad_oe_o, core_in_o;
	logic [`PPDH_PINS-1:0] core_out_i = 8'h3c, core_oe_i = 8'h0f;
	logic [1:0] core_buried_i = 2'h2, buried_fb_o;
	int n_errors = 0, tests_run = 0;
	always #50 clk_i = ~clk_i;
	ppdh_top i_dut (.*);
	ppdh_sys_model i_sys (.clk_i, .sleep_a_cmd_i(cmd_a), .sleep_b_cmd_i(cmd_b),
		.sleep_pin_a_o(sleep_pin_a_i), .sleep_pin_b_o(sleep_pin_b_i), .pad_o(pad_in_i));
	task chk(input string name, input logic [7:0] exp, got);
		tests_run++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s exp %h got %h", name, exp, got);
			n_errors++;
		end
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Release has been requested; count cycles from the pin fall until the core runs
	task wait_run(input string name, input logic [7:0] out);
		int n;
		logic moved;
		@(posedge clk_i);
		n = 0;
		moved = 1'b0;
		while (core_run_o !== 1'b1 && n < 20)
		begin
			if (pad_out_o !== out)
				moved = 1'b1;
			@(negedge clk_i);
			n++;
		end
		chk(name, 1, n <= `PPDH_WAKE_CYC + 1);
		chk("kept", 0, moved);
		if (n >= 20)
			wrap_up;
	endtask
	// Sleep by one pin, disturb everything, wake and resume
	task t_sleep(input bit use_b);
		logic [7:0] pin, out, oe;
		logic [1:0] bur;
		@(posedge clk_i);
		cmd_a <= !use_b;
		cmd_b <= use_b;
		@(negedge clk_i);
		pin = pad_in_i;
		out = core_out_i;
		oe = core_oe_i;
		bur = core_buried_i;
		repeat (2) @(posedge clk_i);
		core_out_i <= ~out;
		core_oe_i <= ~oe;
		core_buried_i <= ~bur;
		repeat (5) @(negedge clk_i);
		chk("asleep", 1, asleep_o && !core_run_o);
		chk("pad_out", out, pad_out_o);
		chk("pad_oe", oe, pad_oe_o);
		chk("core_in", pin, core_in_o);
		chk("buried", {6'h00, bur}, buried_fb_o);
		chk("sleep_out", 0, core_sleep_a_o | core_sleep_b_o);
		@(posedge clk_i);
		cmd_a <= 1'b0;
		cmd_b <= 1'b0;
		wait_run("wake", out);
		pin = pad_in_i;
		@(negedge clk_i);
		chk("resume", ~oe, pad_oe_o);
		chk("resume_in", pin, core_in_o);
		chk("buried_run", {6'h00, ~bur}, buried_fb_o);
	endtask
	// Both pins, one released early, sleep raised again during wake
	task t_both;
		logic [7:0] out;
		@(posedge clk_i);
		cmd_a <= 1'b1;
		cmd_b <= 1'b1;
		@(negedge clk_i);
		out = core_out_i;
		repeat (3) @(posedge clk_i);
		core_out_i <= ~out;
		cmd_a <= 1'b0;
		repeat (4) @(negedge clk_i);
		chk("one_pin", 1, asleep_o && !core_run_o);
		@(posedge clk_i);
		cmd_b <= 1'b0;
		repeat (4) @(posedge clk_i);
		cmd_b <= 1'b1;
		repeat (12) @(negedge clk_i);
		chk("rearm", 1, asleep_o && !core_run_o);
		chk("rearm_out", out, pad_out_o);
		@(posedge clk_i);
		cmd_b <= 1'b0;
		wait_run("rearm_wake", out);
	endtask
	// Option off: sleep pins are plain inputs
	task t_off;
		logic [7:0] p;
		@(posedge clk_i);
		nrst_i <= 1'b0;
		sleep_enable_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		cmd_a <= 1'b1;
		cmd_b <= 1'b1;
		repeat (4) @(negedge clk_i);
		chk("off_asleep", 0, asleep_o);
		chk("off_run", 1, core_run_o);
		chk("off_pin", 8'h03, {core_sleep_b_o, core_sleep_a_o});
		p = pad_in_i;
		@(negedge clk_i);
		chk("off_track", p, core_in_o);
		@(posedge clk_i);
		cmd_a <= 1'b0;
		cmd_b <= 1'b0;
	endtask
	initial
	begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_sleep(0);
		t_sleep(1);
		t_both;
		t_off;
		wrap_up;
	end
endmodule
`default_nettype wire
